// file: iplr_pkg.sv
package iplr_pkg;

  // ********************************************************
  // Bus and register map
  // ********************************************************
  localparam int          IPLR_ADDR_W       = 32;
  localparam int          IPLR_DATA_W       = 32;
  localparam int          IPLR_REG_W        = 16;
  localparam int          IPLR_NUM_REG      = 4;
  localparam logic [2:0]  IPLR_IDX_DEBUG_A  = 3'h0;
  localparam logic [2:0]  IPLR_IDX_DEBUG_B  = 3'h1;
  localparam logic [2:0]  IPLR_IDX_SYSTEM   = 3'h2;
  localparam logic [2:0]  IPLR_IDX_PORT_CAN = 3'h3;
  localparam logic [2:0]  IPLR_IDX_FWD_STAT = 3'h4;
  localparam logic [15:0] IPLR_RESET_VALUE  = 16'h0000;
  localparam logic [15:0] IPLR_MASK_DEBUG_A  = 16'h3C00;
  localparam logic [15:0] IPLR_MASK_DEBUG_B  = 16'h003F;
  localparam logic [15:0] IPLR_MASK_SYSTEM   = 16'hFFCF;
  localparam logic [15:0] IPLR_MASK_PORT_CAN = 16'hFFFC;

  // ********************************************************
  // Priority field codes
  // ********************************************************
  localparam logic [1:0] IPLR_CODE_DISABLED = 2'h0;
  localparam logic [1:0] IPLR_DEBUG_OFFSET  = 2'h0;
  localparam logic [1:0] IPLR_OTHER_OFFSET  = 2'h1;

  // ********************************************************
  // Source table: register index, field low bit, debug class
  // ********************************************************
  localparam int IPLR_NUM_SRC = 19;
  localparam int IPLR_SRC_REG [IPLR_NUM_SRC] = '{
    0, 0,             // breakpoint0_prio, step_counter_prio
    1, 1, 1,          // debug_rx_full_prio, debug_tx_empty_prio, trace_buffer_prio
    2, 2, 2, 2, 2,    // flash_buffers_empty, flash_cmd_done, flash_fault, pll_lost, low_voltage
    2, 2,             // ext_pin_b_prio, ext_pin_a_prio
    3, 3, 3,          // port_d_prio, port_e_prio, port_f_prio
    3, 3, 3, 3        // can_mailbox_prio, can_wake_prio, can_fault_prio, can_busoff_prio
  };
  localparam int IPLR_SRC_LSB [IPLR_NUM_SRC] = '{
    12, 10,
    4, 2, 0,
    14, 12, 10, 8, 6,
    2, 0,
    14, 12, 10,
    8, 6, 4, 2
  };
  localparam bit IPLR_SRC_DEBUG [IPLR_NUM_SRC] = '{
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0
  };

endpackage

// file: iplr_regs.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

module iplr_regs
  import iplr_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [IPLR_ADDR_W-1:0]        wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [IPLR_DATA_W-1:0]        wb_dat_i,
  output logic      [IPLR_DATA_W-1:0]        wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [IPLR_NUM_SRC-1:0]       srcRequest,
  output logic      [IPLR_NUM_SRC-1:0]       arbRequest,
  output logic      [2*IPLR_NUM_SRC-1:0]     arbLevel,
  output logic      [IPLR_NUM_SRC-1:0]       srcEnabled
);

  // ********************************************************
  // Functions
  // ********************************************************
  function automatic logic [1:0] decodeLevel(input logic [1:0] code, input bit isDebug);
    logic [1:0] offs;
    offs = isDebug ? IPLR_DEBUG_OFFSET : IPLR_OTHER_OFFSET;
    decodeLevel = code - offs;
  endfunction

  function automatic logic [15:0] regMask(input logic [2:0] idx);
    logic [15:0] m;
    m = 16'h0000;
    case (idx)
      IPLR_IDX_DEBUG_A:  m = IPLR_MASK_DEBUG_A;
      IPLR_IDX_DEBUG_B:  m = IPLR_MASK_DEBUG_B;
      IPLR_IDX_SYSTEM:   m = IPLR_MASK_SYSTEM;
      IPLR_IDX_PORT_CAN: m = IPLR_MASK_PORT_CAN;
      default:           m = 16'h0000;
    endcase
    regMask = m;
  endfunction

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic                    ack_reg;
  logic [IPLR_DATA_W-1:0]  rdData_reg;
  logic [IPLR_REG_W-1:0]   regBank_reg [IPLR_NUM_REG];
  logic [IPLR_NUM_SRC-1:0] arbRequest_reg;
  logic [2*IPLR_NUM_SRC-1:0] arbLevel_reg;

  wire logic        busReq;
  wire logic        wordAligned;
  wire logic        highZero;
  wire logic [2:0]  regIdx;
  wire logic        hitPrio;
  wire logic        hitStat;
  wire logic        wrEn;
  wire logic [15:0] byteMask;
  wire logic [15:0] wrMask;
  wire logic [15:0] prioRead;
  wire logic [IPLR_DATA_W-1:0] rdNext;

  assign busReq      = wb_cyc_i & wb_stb_i;
  assign wordAligned = (wb_adr_i[1:0] == 2'h0);
  assign highZero    = (wb_adr_i[IPLR_ADDR_W-1:5] == 27'h0000000);
  assign regIdx      = wb_adr_i[4:2];
  assign hitPrio     = wordAligned & highZero & (regIdx < IPLR_IDX_FWD_STAT);
  assign hitStat     = wordAligned & highZero & (regIdx == IPLR_IDX_FWD_STAT);
  // Write lands on the edge where the master samples ack
  assign wrEn        = busReq & wb_we_i & ack_reg & hitPrio;
  assign byteMask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrMask      = byteMask & regMask(regIdx);
  assign prioRead    = hitPrio ? (regBank_reg[regIdx[1:0]] & regMask(regIdx)) : 16'h0000;
  assign rdNext      = hitStat ? {13'h0000, arbRequest_reg}
                               : {16'h0000, prioRead};

  // ********************************************************
  // Wishbone handshake
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h00000000;
    end else begin
      ack_reg <= busReq & ~ack_reg;
      if (busReq & ~ack_reg) begin
        rdData_reg <= rdNext;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // ********************************************************
  // Priority registers
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < IPLR_NUM_REG; r++) begin
        regBank_reg[r] <= IPLR_RESET_VALUE;
      end
    end else if (wrEn) begin
      regBank_reg[regIdx[1:0]] <= (regBank_reg[regIdx[1:0]] & ~wrMask)
                                | (wb_dat_i[15:0] & wrMask);
    end
  end

  // ********************************************************
  // Field decode toward arbitration
  // ********************************************************
  wire logic [IPLR_NUM_SRC-1:0]   enabledNext;
  wire logic [2*IPLR_NUM_SRC-1:0] levelNext;

  for (genvar i = 0; i < IPLR_NUM_SRC; i++) begin : gSrc
    wire logic [1:0] code;
    assign code = regBank_reg[IPLR_SRC_REG[i]][IPLR_SRC_LSB[i] +: 2];
    assign enabledNext[i] = (code != IPLR_CODE_DISABLED);
    assign levelNext[2*i +: 2] = enabledNext[i] ?
                                 decodeLevel(code, IPLR_SRC_DEBUG[i]) : 2'h0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arbRequest_reg <= 19'h00000;
      arbLevel_reg   <= 38'h0000000000;
    end else begin
      arbRequest_reg <= srcRequest & enabledNext;
      arbLevel_reg   <= levelNext;
    end
  end

  assign arbRequest = arbRequest_reg;
  assign arbLevel   = arbLevel_reg;
  assign srcEnabled = enabledNext;

endmodule

`default_nettype wire

// file: iplr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module iplr_regs_props
  import iplr_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [IPLR_DATA_W-1:0]    wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic [IPLR_NUM_SRC-1:0]   srcRequest,
  input wire logic [IPLR_NUM_SRC-1:0]   arbRequest,
  input wire logic [2*IPLR_NUM_SRC-1:0] arbLevel,
  input wire logic [IPLR_NUM_SRC-1:0]   srcEnabled
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_dat_upper: assert property (wb_dat_o[31:19] == 13'h0000) else $error("upper bits");
  a_arb_gate: assert property (
    1 |=> arbRequest == ($past(srcRequest) & $past(srcEnabled)))
    else $error("bad gating");
  a_cfg_quiet: assert property (
    !$stable(srcEnabled) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("enable moved");
  a_reset_off: assert property (
    disable iff (1'b0) rst |-> srcEnabled == '0 && arbRequest == '0)
    else $error("not cleared");
  for (genvar i = 0; i < IPLR_NUM_SRC; i++) begin : g_src
    a_level_off: assert property (
      !$past(srcEnabled[i]) |-> arbLevel[2*i+:2] == 2'h0)
      else $error("level while off");
    a_level_min: assert property (
      $past(srcEnabled[i]) && i < 5 |-> arbLevel[2*i+:2] != 2'h0)
      else $error("debug level zero");
    a_level_max: assert property (
      i >= 5 |-> arbLevel[2*i+:2] != 2'h3)
      else $error("level above two");
  end
endmodule
`default_nettype wire

// file: iplr_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module iplr_src_model
  import iplr_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic [IPLR_NUM_SRC-1:0] raise,
  output logic      [IPLR_NUM_SRC-1:0] srcRequest
);
  // Sources hold a level request in the system clock domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srcRequest <= '0;
    end else begin
      srcRequest <= raise;
    end
  end
endmodule
`default_nettype wire

// file: irq_priority_level_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_priority_level_regs_tb
  import iplr_pkg::*;
;
  logic                      mclk = 1'b0, rst, cyc, stb, we, ack;
  logic [3:0]                sel;
  logic [3:0]                busSel = 4'hF;
  logic [31:0]               adr, wdat, dout, rd;
  logic [IPLR_NUM_SRC-1:0]   raise, srcReq, arbReq, srcEn;
  logic [37:0]               arbLvl, expLvl;
  logic [15:0]               msk [4] = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
  int                        errCount = 0, checks = 0;
  always #2.5 mclk = ~mclk;
  iplr_src_model src (.mclk(mclk), .rst(rst), .raise(raise), .srcRequest(srcReq));
  iplr_regs dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .srcRequest(srcReq), .arbRequest(arbReq), .arbLevel(arbLvl), .srcEnabled(srcEn));
  task automatic finish_test();
    if (errCount == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, busSel};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dout;
    {cyc, stb} <= 2'b00;
    check(38'(ack), 38'h1);
    if (ack !== 1'b1) finish_test();
  endtask
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, wdat, sel, raise} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      bus(1'b0, 32'(r * 4), 32'h0);
      check(38'(rd), 38'h0);
      bus(1'b1, 32'(r * 4), 32'hFFFF);
      bus(1'b0, 32'(r * 4), 32'h0);
      check(38'(rd), 38'(msk[r]));
      bus(1'b1, 32'(r * 4), 32'hA5A5);
      bus(1'b0, 32'(r * 4), 32'h0);
      check(38'(rd), 38'(msk[r] & 16'hA5A5));
    end
    bus(1'b1, 32'h14, 32'hFFFF);
    bus(1'b0, 32'h14, 32'h0);
    check(38'(rd), 38'h0);
    // Upper byte lane only: the low-voltage and external pin fields in the low byte must survive
    busSel = 4'h2;
    bus(1'b1, 32'h8, 32'h0);
    busSel = 4'hF;
    bus(1'b0, 32'h8, 32'h0);
    check(38'(rd), 38'h0085);
    raise <= '1;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) bus(1'b1, 32'(r * 4), {16'h0, {8{2'(c)}}});
      repeat (2) @(posedge mclk);
      for (int i = 0; i < IPLR_NUM_SRC; i++) expLvl[2*i+:2] = (c == 0) ? 2'h0 : 2'(i < 5 ? c : c - 1);
      check(arbLvl, expLvl);
      check(38'(srcEn), (c == 0) ? 38'h0 : 38'h7FFFF);
      check(38'(arbReq), (c == 0) ? 38'h0 : 38'h7FFFF);
    end
    // One cycle in the source model, one in the forwarding register
    raise <= 19'h0A5;
    repeat (3) @(posedge mclk);
    check(38'(arbReq), 38'h0A5);
    bus(1'b0, 32'h10, 32'h0);
    check(38'(rd), 38'h0A5);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, 32'hC, 32'h0);
    check(38'(rd), 38'h0);
    check(38'(srcEn), 38'h0);
    check(arbLvl, 38'h0);
    check(38'(arbReq), 38'h0);
    finish_test();
  end
endmodule
bind iplr_regs iplr_regs_props u_props (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .srcRequest(srcRequest), .arbRequest(arbRequest), .arbLevel(arbLevel),
  .srcEnabled(srcEnabled));
`default_nettype wire
